//--- src/adc_cfg_pkg.sv
// Package: offsets, field positions and reset values of the converter configuration bank
package adc_cfg_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0]  IDX_CLK_CHAN   = 8'h03;
  localparam logic [7:0]  IDX_GAIN       = 8'h04;
  localparam logic [7:0]  IDX_CHOP       = 8'h06;
  localparam logic [9:0]  ADDR_CLK_CHAN  = 10'h00C;
  localparam logic [9:0]  ADDR_GAIN      = 10'h010;
  localparam logic [9:0]  ADDR_CHOP      = 10'h018;

  // Reset values
  localparam logic [15:0] RST_CLK_CHAN   = 16'h0F8E;
  localparam logic [15:0] RST_GAIN       = 16'h0000;
  localparam logic [15:0] RST_CHOP       = 16'h0600;

  // Field positions
  localparam int          CHAN_EN_LSB    = 8;
  localparam int          CLK_SEL_BIT    = 7;
  localparam int          OSR_LSB        = 2;
  localparam int          PWR_LSB        = 0;
  localparam int          GAIN_STRIDE    = 4;
  localparam int          CHOP_DLY_LSB   = 9;
  localparam int          CHOP_EN_BIT    = 8;

  // Writable masks; clock register bits 15:12 are read-only zero
  localparam logic [15:0] MASK_CLK_CHAN  = 16'h0FFF;
  localparam logic [15:0] MASK_GAIN      = 16'hFFFF;
  localparam logic [15:0] MASK_CHOP      = 16'hFFFF;

  // Decoded values
  localparam int          OSR_MIN_LOG2   = 7;
  localparam int          CHOP_DLY_ADD   = 1;

  // Power mode codes
  localparam logic [1:0]  PWR_VERY_LOW   = 2'h0;
  localparam logic [1:0]  PWR_LOW        = 2'h1;

  // Bus encodings
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ     = 2'h3;

  typedef enum logic [2:0] {
    PM_VERY_LOW = 3'h1,
    PM_LOW      = 3'h2,
    PM_HIGH_RES = 3'h4
  } power_mode_t;

endpackage

//--- src/cfg_word_reg.sv
// Masked 16-bit configuration word with per-byte write strobes
`timescale 1ns/1ps
module cfg_word_reg #(
  parameter logic [15:0] RESET_VALUE = 16'h0000,
  parameter logic [15:0] WRITE_MASK  = 16'hFFFF
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Write port
  input  wire logic [1:0]  byte_wr,
  input  wire logic [15:0] wr_data,
  // Stored word
  output logic      [15:0] value_q
);

  logic [15:0] value_d;

  always_comb begin
    value_d = value_q;
    if (byte_wr[0]) begin
      value_d[7:0] = wr_data[7:0];
    end
    if (byte_wr[1]) begin
      value_d[15:8] = wr_data[15:8];
    end
    // Read-only bits always hold their reset content
    value_d = (value_d & WRITE_MASK) | (RESET_VALUE & ~WRITE_MASK);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      value_q <= RESET_VALUE;
    end else begin
      value_q <= value_d;
    end
  end

endmodule

//--- src/cfg_decode.sv
// Decodes stored configuration fields into one-hot and exponent forms
`timescale 1ns/1ps
module cfg_decode (
  // Raw fields
  input  wire logic [1:0]  power_mode_code,
  input  wire logic [2:0]  oversample_ratio_code,
  input  wire logic [3:0]  chop_settle_delay_code,
  // Decoded values
  output adc_cfg_pkg::power_mode_t power_mode,
  output logic      [4:0]  osr_log2,
  output logic      [4:0]  chop_delay_log2
);

  always_comb begin
    case (power_mode_code)
      adc_cfg_pkg::PWR_VERY_LOW: power_mode = adc_cfg_pkg::PM_VERY_LOW;
      adc_cfg_pkg::PWR_LOW:      power_mode = adc_cfg_pkg::PM_LOW;
      default:                   power_mode = adc_cfg_pkg::PM_HIGH_RES;
    endcase
  end

  assign osr_log2        = 5'(oversample_ratio_code) + 5'(adc_cfg_pkg::OSR_MIN_LOG2);
  assign chop_delay_log2 = 5'(chop_settle_delay_code) + 5'(adc_cfg_pkg::CHOP_DLY_ADD);

endmodule

//--- src/adc_cfg_bank.sv
// AHB-Lite register bank holding converter clock, gain and chop configuration
`timescale 1ns/1ps
module adc_cfg_bank (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic        HREADY,
  input  wire logic [31:0] HWDATA,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // Channel and clock configuration
  output logic      [3:0]  CHAN_CONVERT_ON,
  output logic             EXT_CLOCK_SELECT,
  output logic      [2:0]  OVERSAMPLE_RATIO_CODE,
  output logic      [4:0]  OVERSAMPLE_RATIO_LOG2,
  output logic      [1:0]  POWER_MODE_CODE,
  output logic      [2:0]  POWER_MODE_ONEHOT,
  // Gain configuration
  output logic      [11:0] CHAN_GAIN_CODE,
  output logic      [11:0] CHAN_GAIN_LOG2,
  // Chop configuration
  output logic             CHOP_MODE_ON,
  output logic      [3:0]  CHOP_SETTLE_DELAY_CODE,
  output logic      [4:0]  CHOP_SETTLE_DELAY_LOG2
);

  // Which register a byte address selects
  function automatic logic [2:0] reg_hit(input logic [31:0] addr);
    reg_hit[0] = (addr[31:0] == {22'h0, adc_cfg_pkg::ADDR_CLK_CHAN});
    reg_hit[1] = (addr[31:0] == {22'h0, adc_cfg_pkg::ADDR_GAIN});
    reg_hit[2] = (addr[31:0] == {22'h0, adc_cfg_pkg::ADDR_CHOP});
  endfunction

  logic        wr_pend_q;
  logic [2:0]  wr_sel_q;
  logic [2:0]  rd_sel;
  logic [1:0]  byte_wr [3];
  logic [15:0] clk_chan_q;
  logic [15:0] gain_q;
  logic [15:0] chop_q;
  logic        phase_ok;
  logic        rd_req;
  adc_cfg_pkg::power_mode_t power_mode;

  // Zero wait state slave: always ready, always OKAY
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign phase_ok  = HSEL && HREADY &&
                     (HTRANS == adc_cfg_pkg::HTRANS_NONSEQ ||
                      HTRANS == adc_cfg_pkg::HTRANS_SEQ);
  assign rd_req    = phase_ok && !HWRITE;
  assign rd_sel    = reg_hit(HADDR);

  // Latch write address phase for use in the data phase
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wr_pend_q <= 1'b0;
      wr_sel_q  <= 3'h0;
    end else begin
      wr_pend_q <= phase_ok && HWRITE;
      wr_sel_q  <= (phase_ok && HWRITE) ? reg_hit(HADDR) : 3'h0;
    end
  end

  // Registers are 16 bits: only the low two byte lanes can land
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_strobe
      assign byte_wr[gi] = {2{wr_pend_q && wr_sel_q[gi]}};
    end
  endgenerate

  cfg_word_reg #(
    .RESET_VALUE (adc_cfg_pkg::RST_CLK_CHAN),
    .WRITE_MASK  (adc_cfg_pkg::MASK_CLK_CHAN)
  ) u_clk_chan (
    .clk     (CLK),
    .reset_n (RESET_N),
    .byte_wr (byte_wr[0]),
    .wr_data (HWDATA[15:0]),
    .value_q (clk_chan_q)
  );

  cfg_word_reg #(
    .RESET_VALUE (adc_cfg_pkg::RST_GAIN),
    .WRITE_MASK  (adc_cfg_pkg::MASK_GAIN)
  ) u_gain (
    .clk     (CLK),
    .reset_n (RESET_N),
    .byte_wr (byte_wr[1]),
    .wr_data (HWDATA[15:0]),
    .value_q (gain_q)
  );

  cfg_word_reg #(
    .RESET_VALUE (adc_cfg_pkg::RST_CHOP),
    .WRITE_MASK  (adc_cfg_pkg::MASK_CHOP)
  ) u_chop (
    .clk     (CLK),
    .reset_n (RESET_N),
    .byte_wr (byte_wr[2]),
    .wr_data (HWDATA[15:0]),
    .value_q (chop_q)
  );

  // Read data registered at the address phase; a write landing at that same edge is not yet seen
  // clock bits 15:12 read zero
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      HRDATA <= 32'h00000000;
    end else if (rd_req) begin
      case (1'b1)
        rd_sel[0]: HRDATA <= {16'h0000, clk_chan_q & adc_cfg_pkg::MASK_CLK_CHAN};
        rd_sel[1]: HRDATA <= {16'h0000, gain_q};
        rd_sel[2]: HRDATA <= {16'h0000, chop_q};
        default:   HRDATA <= 32'h00000000;
      endcase
    end
  end

  assign CHAN_CONVERT_ON       = clk_chan_q[adc_cfg_pkg::CHAN_EN_LSB +: 4];
  assign EXT_CLOCK_SELECT      = clk_chan_q[adc_cfg_pkg::CLK_SEL_BIT];
  assign OVERSAMPLE_RATIO_CODE = clk_chan_q[adc_cfg_pkg::OSR_LSB +: 3];
  assign POWER_MODE_CODE       = clk_chan_q[adc_cfg_pkg::PWR_LSB +: 2];
  assign CHOP_MODE_ON          = chop_q[adc_cfg_pkg::CHOP_EN_BIT];
  assign CHOP_SETTLE_DELAY_CODE = chop_q[adc_cfg_pkg::CHOP_DLY_LSB +: 4];
  assign POWER_MODE_ONEHOT     = power_mode;

  // gain field placement; log2 of gain equals the code
  generate
    for (gi = 0; gi < 4; gi++) begin : g_gain
      assign CHAN_GAIN_CODE[gi*3 +: 3] = gain_q[gi*adc_cfg_pkg::GAIN_STRIDE +: 3];
      assign CHAN_GAIN_LOG2[gi*3 +: 3] = gain_q[gi*adc_cfg_pkg::GAIN_STRIDE +: 3];
    end
  endgenerate

  // decode of ratio, mode and delay
  cfg_decode u_decode (
    .power_mode_code        (POWER_MODE_CODE),
    .oversample_ratio_code  (OVERSAMPLE_RATIO_CODE),
    .chop_settle_delay_code (CHOP_SETTLE_DELAY_CODE),
    .power_mode             (power_mode),
    .osr_log2               (OVERSAMPLE_RATIO_LOG2),
    .chop_delay_log2        (CHOP_SETTLE_DELAY_LOG2)
  );

  // Checks
  sequence s_wr_addr(logic [9:0] a);
    phase_ok && HWRITE && HADDR == {22'h0, a};
  endsequence

  // Read address phase; data is loaded at this same edge
  sequence s_rd_addr(logic [9:0] a);
    phase_ok && !HWRITE && HADDR == {22'h0, a};
  endsequence

  a_clk_reserved_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_rd_addr(adc_cfg_pkg::ADDR_CLK_CHAN) |=> HRDATA[31:12] == 20'h00000)
    else $error("clock register reserved bits not zero");

  a_chan_en_write: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_wr_addr(adc_cfg_pkg::ADDR_CLK_CHAN) ##1 1'b1 |=> CHAN_CONVERT_ON == $past(HWDATA[11:8]))
    else $error("channel enables not written");

  a_clk_sel_write: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_wr_addr(adc_cfg_pkg::ADDR_CLK_CHAN) ##1 1'b1 |=> EXT_CLOCK_SELECT == $past(HWDATA[7]))
    else $error("clock select not written");

  a_osr_decode: assert property (@(posedge CLK) disable iff (!RESET_N)
    OVERSAMPLE_RATIO_LOG2 == 5'(OVERSAMPLE_RATIO_CODE) + 5'd7) else $error("bad ratio decode");

  a_power_decode: assert property (@(posedge CLK) disable iff (!RESET_N)
    POWER_MODE_CODE[1] |-> POWER_MODE_ONEHOT == 3'h4) else $error("bad power decode");

  a_gain_write: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_wr_addr(adc_cfg_pkg::ADDR_GAIN) ##1 1'b1
    |=> CHAN_GAIN_CODE[11:9] == $past(HWDATA[14:12])) else $error("gain 3 not written");

  a_chop_delay_decode: assert property (@(posedge CLK) disable iff (!RESET_N)
    CHOP_SETTLE_DELAY_LOG2 == 5'(CHOP_SETTLE_DELAY_CODE) + 5'd1) else $error("bad delay decode");

  a_chop_en_write: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_wr_addr(adc_cfg_pkg::ADDR_CHOP) ##1 1'b1 |=> CHOP_MODE_ON == $past(HWDATA[8]))
    else $error("chop enable not written");

  a_gain_hold: assert property (@(posedge CLK) disable iff (!RESET_N)
    !wr_pend_q || !wr_sel_q[1] |=> $stable(gain_q)) else $error("gain changed without write");

  a_chop_reset_code: assert property (@(posedge CLK)
    $rose(RESET_N) |-> CHOP_SETTLE_DELAY_CODE == 4'h3) else $error("chop delay reset wrong");

  // Remaining reset values, seen at the first edge after release
  a_enable_reset: assert property (@(posedge CLK)
    $rose(RESET_N)
    |-> CHAN_CONVERT_ON == 4'hF)
    else $error("channel enables reset wrong");

  a_clk_sel_reset: assert property (@(posedge CLK)
    $rose(RESET_N)
    |-> EXT_CLOCK_SELECT == 1'b1)
    else $error("clock select reset wrong");

  a_osr_reset: assert property (@(posedge CLK)
    $rose(RESET_N)
    |-> OVERSAMPLE_RATIO_CODE == 3'h3)
    else $error("oversampling code reset wrong");

  a_power_reset: assert property (@(posedge CLK)
    $rose(RESET_N)
    |-> POWER_MODE_CODE == 2'h2)
    else $error("power code reset wrong");

  a_gain_reset: assert property (@(posedge CLK)
    $rose(RESET_N)
    |-> CHAN_GAIN_CODE == 12'h000)
    else $error("gain codes reset wrong");

  a_chop_off_reset: assert property (@(posedge CLK)
    $rose(RESET_N)
    |-> CHOP_MODE_ON == 1'b0)
    else $error("chop enable reset wrong");

  a_delay_log2_reset: assert property (@(posedge CLK)
    $rose(RESET_N)
    |-> CHOP_SETTLE_DELAY_LOG2 == 5'h04)
    else $error("chop delay exponent reset wrong");

  // Fields land at the edge ending the data phase
  a_osr_write: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_wr_addr(adc_cfg_pkg::ADDR_CLK_CHAN) ##1 1'b1
    |=> OVERSAMPLE_RATIO_CODE == $past(HWDATA[4:2]))
    else $error("oversampling code not written");

  a_power_write: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_wr_addr(adc_cfg_pkg::ADDR_CLK_CHAN) ##1 1'b1
    |=> POWER_MODE_CODE == $past(HWDATA[1:0]))
    else $error("power code not written");

  a_gain0_write: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_wr_addr(adc_cfg_pkg::ADDR_GAIN) ##1 1'b1
    |=> CHAN_GAIN_CODE[2:0] == $past(HWDATA[2:0]))
    else $error("gain 0 not written");

  a_gain1_write: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_wr_addr(adc_cfg_pkg::ADDR_GAIN) ##1 1'b1
    |=> CHAN_GAIN_CODE[5:3] == $past(HWDATA[6:4]))
    else $error("gain 1 not written");

  a_gain2_write: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_wr_addr(adc_cfg_pkg::ADDR_GAIN) ##1 1'b1
    |=> CHAN_GAIN_CODE[8:6] == $past(HWDATA[10:8]))
    else $error("gain 2 not written");

  a_delay_write: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_wr_addr(adc_cfg_pkg::ADDR_CHOP) ##1 1'b1
    |=> CHOP_SETTLE_DELAY_CODE == $past(HWDATA[12:9]))
    else $error("chop delay not written");

  // Low power codes; both upper codes are covered above
  a_power_vlow_decode: assert property (@(posedge CLK) disable iff (!RESET_N)
    POWER_MODE_CODE == 2'h0
    |-> POWER_MODE_ONEHOT == 3'h1)
    else $error("bad very-low power decode");

  a_power_low_decode: assert property (@(posedge CLK) disable iff (!RESET_N)
    POWER_MODE_CODE == 2'h1
    |-> POWER_MODE_ONEHOT == 3'h2)
    else $error("bad low power decode");

  // Read data carries the word stored before the address edge
  a_chan_en_read: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_rd_addr(adc_cfg_pkg::ADDR_CLK_CHAN)
    |=> HRDATA[11:8] == $past(CHAN_CONVERT_ON))
    else $error("channel enables read wrong");

  a_clk_sel_read: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_rd_addr(adc_cfg_pkg::ADDR_CLK_CHAN)
    |=> HRDATA[7] == $past(EXT_CLOCK_SELECT))
    else $error("clock select read wrong");

  a_osr_read: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_rd_addr(adc_cfg_pkg::ADDR_CLK_CHAN)
    |=> HRDATA[4:2] == $past(OVERSAMPLE_RATIO_CODE))
    else $error("oversampling code read wrong");

  a_power_read: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_rd_addr(adc_cfg_pkg::ADDR_CLK_CHAN)
    |=> HRDATA[1:0] == $past(POWER_MODE_CODE))
    else $error("power code read wrong");

  a_gain_read: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_rd_addr(adc_cfg_pkg::ADDR_GAIN)
    |=> HRDATA == {16'h0000, $past(gain_q)})
    else $error("gain register read wrong");

  a_chop_en_read: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_rd_addr(adc_cfg_pkg::ADDR_CHOP)
    |=> HRDATA[8] == $past(CHOP_MODE_ON))
    else $error("chop enable read wrong");

  a_delay_read: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_rd_addr(adc_cfg_pkg::ADDR_CHOP)
    |=> HRDATA[12:9] == $past(CHOP_SETTLE_DELAY_CODE))
    else $error("chop delay read wrong");

  a_upper_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
    rd_req
    |=> HRDATA[31:16] == 16'h0000)
    else $error("upper read half not zero");

  // Words without a write, and read data between reads, hold
  a_clk_hold: assert property (@(posedge CLK) disable iff (!RESET_N)
    !wr_pend_q || !wr_sel_q[0]
    |=> $stable(clk_chan_q))
    else $error("clock register changed without write");

  a_chop_hold: assert property (@(posedge CLK) disable iff (!RESET_N)
    !wr_pend_q || !wr_sel_q[2]
    |=> $stable(chop_q))
    else $error("chop register changed without write");

  a_rdata_hold: assert property (@(posedge CLK) disable iff (!RESET_N)
    !rd_req
    |=> $stable(HRDATA))
    else $error("read data changed without read");

  a_unmapped_write: assert property (@(posedge CLK) disable iff (!RESET_N)
    phase_ok && HWRITE && reg_hit(HADDR) == 3'h0
    |-> ##2 ($stable(clk_chan_q) && $stable(gain_q) && $stable(chop_q)))
    else $error("unmapped write changed a register");

endmodule

//--- bench/adc_config_register_bank_tb.sv
// Self-checking bench for the converter configuration register bank
`timescale 1ns/1ps
module adc_config_register_bank_tb;
  typedef struct packed {
    logic [9:0]  addr;
    logic [31:0] wdata;
    logic [15:0] rd;
  } row_t;
  localparam row_t ROWS [14] = '{
    '{10'h00C, 32'h0000FF9F, 16'h0F9F}, '{10'h00C, 32'h00000000, 16'h0000},
    '{10'h00C, 32'h00000A05, 16'h0A05}, '{10'h00C, 32'h0000039E, 16'h039E},
    '{10'h00C, 32'hABCD0C97, 16'h0C97}, '{10'h00C, 32'h0000050B, 16'h050B},
    '{10'h010, 32'h00007654, 16'h7654}, '{10'h010, 32'h00003210, 16'h3210},
    '{10'h010, 32'h00007777, 16'h7777}, '{10'h018, 32'h00001F00, 16'h1F00},
    '{10'h018, 32'h00001A00, 16'h1A00}, '{10'h018, 32'h00000000, 16'h0000},
    '{10'h014, 32'h0000FFFF, 16'h0000}, '{10'h008, 32'h0000FFFF, 16'h0000}};
  logic        clk;
  logic        reset_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  wire         hready;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [3:0]  chan_on;
  logic        ext_clk;
  logic [2:0]  osr_code;
  logic [4:0]  osr_log2;
  logic [1:0]  pwr_code;
  logic [2:0]  pwr_onehot;
  logic [11:0] gain_code;
  logic [11:0] gain_log2;
  logic        chop_on;
  logic [3:0]  dly_code;
  logic [4:0]  dly_log2;
  logic [15:0] s_clk;
  logic [15:0] s_gain;
  logic [15:0] s_chop;
  logic [31:0] rd;
  int          n_mismatch;
  int          checks;
  // Single slave, so its ready drives the bus ready
  assign hready = hreadyout;
  adc_cfg_bank i_dut (
    .CLK(clk), .RESET_N(reset_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HREADY(hready), .HWDATA(hwdata), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .CHAN_CONVERT_ON(chan_on),
    .EXT_CLOCK_SELECT(ext_clk), .OVERSAMPLE_RATIO_CODE(osr_code),
    .OVERSAMPLE_RATIO_LOG2(osr_log2), .POWER_MODE_CODE(pwr_code),
    .POWER_MODE_ONEHOT(pwr_onehot), .CHAN_GAIN_CODE(gain_code), .CHAN_GAIN_LOG2(gain_log2),
    .CHOP_MODE_ON(chop_on), .CHOP_SETTLE_DELAY_CODE(dly_code),
    .CHOP_SETTLE_DELAY_LOG2(dly_log2));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wait_ready;
    do @(posedge clk); while (hready !== 1'b1);
  endtask
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= adc_cfg_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr  <= {22'h0, a};
    wait_ready();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
    check("response", {31'h0, hresp}, 32'h0);
  endtask
  task automatic check_outputs;
    check("enables", chan_on, s_clk[11:8]);
    check("clock select", ext_clk, s_clk[7]);
    check("osr code", osr_code, s_clk[4:2]);
    check("osr log2", osr_log2, {2'h0, s_clk[4:2]} + 5'h07);
    check("power code", pwr_code, s_clk[1:0]);
    check("power mode", pwr_onehot, (s_clk[1:0] == 2'h0) ? 3'h1 :
          (s_clk[1:0] == 2'h1) ? 3'h2 : 3'h4);
    check("gain code", gain_code, {s_gain[14:12], s_gain[10:8], s_gain[6:4], s_gain[2:0]});
    check("gain log2", gain_log2, {s_gain[14:12], s_gain[10:8], s_gain[6:4], s_gain[2:0]});
    check("chop on", chop_on, s_chop[8]);
    check("delay code", dly_code, s_chop[12:9]);
    check("delay log2", dly_log2, {1'h0, s_chop[12:9]} + 5'h01);
  endtask
  task automatic check_reset_state;
    s_clk  = 16'h0F8E;
    s_gain = 16'h0000;
    s_chop = 16'h0600;
    check_outputs();
    bus(1'b0, adc_cfg_pkg::ADDR_CLK_CHAN, 32'h0);
    check("clock reg", rd, 32'h00000F8E);
    bus(1'b0, adc_cfg_pkg::ADDR_GAIN, 32'h0);
    check("gain reg", rd, 32'h00000000);
    bus(1'b0, adc_cfg_pkg::ADDR_CHOP, 32'h0);
    check("chop reg", rd, 32'h00000600);
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Rows plus a few cycles each; far beyond any normal run
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end
  initial begin
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    n_mismatch = 0;
    checks = 0;
    repeat (12) @(posedge clk);
    check("rdata in reset", hrdata, 32'h0);
    reset_n <= 1'b1;
    check_reset_state();
    foreach (ROWS[i]) begin
      bus(1'b1, ROWS[i].addr, ROWS[i].wdata);
      bus(1'b0, ROWS[i].addr, 32'h0);
      check("readback", rd, {16'h0000, ROWS[i].rd});
      if (ROWS[i].addr == adc_cfg_pkg::ADDR_CLK_CHAN) s_clk = ROWS[i].rd;
      if (ROWS[i].addr == adc_cfg_pkg::ADDR_GAIN) s_gain = ROWS[i].rd;
      if (ROWS[i].addr == adc_cfg_pkg::ADDR_CHOP) s_chop = ROWS[i].rd;
      check_outputs();
    end
    // Read in the write's data phase still sees the old word
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= adc_cfg_pkg::HTRANS_NONSEQ;
    hwrite <= 1'b1;
    haddr  <= {22'h0, adc_cfg_pkg::ADDR_GAIN};
    wait_ready();
    hwrite <= 1'b0;
    hwdata <= 32'h00001111;
    wait_ready();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    wait_ready();
    check("old gain", hrdata, 32'h00007777);
    bus(1'b0, adc_cfg_pkg::ADDR_GAIN, 32'h0);
    check("new gain", rd, 32'h00001111);
    s_gain = 16'h1111;
    check_outputs();
    // Second reset in mid-run restores every default
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    check("rdata in reset", hrdata, 32'h0);
    reset_n <= 1'b1;
    check_reset_state();
    finish_test();
  end
endmodule
